// File: rtl/scp_pkg.sv
// shared constants and types for the serial control port and its host
package scp_pkg;
	// frame layout
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 5;
	localparam int RW_POS = 0;
	localparam int ADDR_LSB = 1;
	localparam int ADDR_MSB = 7;
	localparam int DATA_LSB = 8;
	localparam int DATA_MSB = 15;
	// device register addresses
	localparam logic [6:0] ADDR_OUT_LOW = 7'h7b;
	localparam logic [6:0] ADDR_OUT_MID = 7'h7c;
	localparam logic [6:0] ADDR_OUT_HIGH = 7'h7d;
	localparam logic [6:0] ADDR_IGN = 7'h7e;
	localparam logic [6:0] ADDR_COMM_DIAG = 7'h40;
	localparam logic [6:0] ADDR_MAIN_DIAG = 7'h41;
	localparam logic [6:0] ADDR_OP_STATUS = 7'h42;
	localparam logic [6:0] ADDR_FWD_STATUS = 7'h43;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int IGN_W = 4;
	// bit positions inside status bytes
	localparam int CF_BIT = 0;
	localparam int COT_BIT = 1;
	localparam int FRAME_ERR_BIT = 0;
	// host register map (byte addresses)
	localparam logic [11:0] H_CTRL = 12'h000;
	localparam logic [11:0] H_TXDATA = 12'h004;
	localparam logic [11:0] H_STATUS = 12'h008;
	localparam logic [11:0] H_RXDATA = 12'h00c;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_LEN_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_FLAG_BIT = 2;
	localparam logic [CNT_W-1:0] LEN_RESET = 5'h10;
	// timing
	localparam int CORE_CLK_NS = 40;
	localparam int SCLK_HALF_NS = 160;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	// host sequencer states
	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_LEAD = 5'h02,
		H_HIGH = 5'h04,
		H_LOW = 5'h08,
		H_GAP = 5'h10
	} scp_hstate_type;
endpackage

// File: rtl/scp_if.sv
// serial link between host and device, with the shared data-out wire
`timescale 1ns/10ps
interface scp_if;
	logic serial_clock_in;
	logic chip_select_low;
	logic serial_data_in;
	logic serial_data_out;
	logic sdo_oe;
	logic cfg_clock_neg_pin;
	logic cfg_data_neg_pin;
	wire serial_data_line;

	// a released line reads as its pull-up level, never as the last driven bit
	assign serial_data_line = sdo_oe ? serial_data_out : 1'b1;

	modport dev (
		input serial_clock_in,
		input chip_select_low,
		input serial_data_in,
		input cfg_clock_neg_pin,
		input cfg_data_neg_pin,
		output serial_data_out,
		output sdo_oe
	);
	modport host (
		output serial_clock_in,
		output chip_select_low,
		output serial_data_in,
		input serial_data_line
	);
endinterface

// File: rtl/scp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module scp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk, // core clock
	input wire logic nrst, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised outputs
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RST_VAL;
			q_reg <= RST_VAL;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule

// File: rtl/scp_device.sv
// serial control port of the device: frame decode, control registers, answers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module scp_device (
	input wire logic core_clk, // core clock, 25 MHz
	input wire logic nrst, // async reset, active low
	scp_if.dev link, // serial pins
	input wire logic por_active, // power-on reset in progress
	input wire logic wdr_active, // watchdog reset in progress
	input wire logic [7:0] main_diag_in, // main diagnosis content
	input wire logic [7:0] op_status_in, // operating status content
	input wire logic [7:0] fwd_status_in, // functional watchdog status content
	output logic [23:0] output_on, // switch-on bits of outputs 1..24
	output logic [scp_pkg::IGN_W-1:0] ignition_on, // switch-on bits of ignition 1..4
	output logic frame_error_flag, // communication frame error flag
	output logic spi_mode // straps select serial mode
);
	logic [4:0] pin_q;
	logic sclk_d_reg;
	logic csn_d_reg;
	logic [15:0] rx_reg;
	logic [scp_pkg::CNT_W-1:0] cnt_reg;
	logic [15:0] tx_reg;
	logic [15:0] ans_reg;
	logic [15:0] ans_next;
	logic flag_ph_reg;
	logic sdo_reg;
	logic sdo_next;
	logic oe_reg;
	logic [7:0] out_low_reg;
	logic [7:0] out_mid_reg;
	logic [7:0] out_high_reg;
	logic [scp_pkg::IGN_W-1:0] ign_reg;
	logic frame_err_reg;
	logic frame_err_next;
	logic por_d_reg;
	logic wdr_d_reg;

	// pins come from the host's domain; configuration straps also pass the synchroniser
	scp_sync #(
		.W(5),
		.RST_VAL(5'h02)
	) u_pin_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.d({link.cfg_data_neg_pin, link.cfg_clock_neg_pin, link.serial_data_in,
			link.chip_select_low, link.serial_clock_in}),
		.q(pin_q)
	);

	wire sclk_s = pin_q[0];
	wire csn_s = pin_q[1];
	wire sdi_s = pin_q[2];
	wire cfg_clk_s = pin_q[3];
	wire cfg_dat_s = pin_q[4];

	wire sclk_rise = sclk_s & ~sclk_d_reg;
	wire sclk_fall = ~sclk_s & sclk_d_reg;
	wire cs_fall = ~csn_s & csn_d_reg;
	wire cs_rise = csn_s & ~csn_d_reg;

	wire mode_ok = cfg_clk_s & ~cfg_dat_s;
	wire listen = mode_ok & ~por_active & ~wdr_active;
	wire in_frame = listen & ~csn_s;
	wire status_flag = main_diag_in[scp_pkg::CF_BIT] | main_diag_in[scp_pkg::COT_BIT];
	wire por_release = por_d_reg & ~por_active;
	wire wdr_release = wdr_d_reg & ~wdr_active;

	// field split of the received frame
	wire f_rw = rx_reg[scp_pkg::RW_POS];
	wire [6:0] f_addr = rx_reg[scp_pkg::ADDR_MSB:scp_pkg::ADDR_LSB];
	wire [7:0] f_data = rx_reg[scp_pkg::DATA_MSB:scp_pkg::DATA_LSB];

	// register lookup: {exists, writable, content}
	function automatic logic [9:0] reg_lookup(input logic [6:0] addr, input logic [7:0] comm);
		logic [9:0] r;
		r = 10'h000;
		case (addr)
			scp_pkg::ADDR_OUT_LOW: r = {2'b11, out_low_reg};
			scp_pkg::ADDR_OUT_MID: r = {2'b11, out_mid_reg};
			scp_pkg::ADDR_OUT_HIGH: r = {2'b11, out_high_reg};
			scp_pkg::ADDR_IGN: r = {2'b11, {(8 - scp_pkg::IGN_W){1'b0}}, ign_reg};
			scp_pkg::ADDR_COMM_DIAG: r = {2'b10, comm};
			scp_pkg::ADDR_MAIN_DIAG: r = {2'b10, main_diag_in};
			scp_pkg::ADDR_OP_STATUS: r = {2'b10, op_status_in};
			scp_pkg::ADDR_FWD_STATUS: r = {2'b10, fwd_status_in};
			default: r = 10'h000;
		endcase
		return r;
	endfunction

	wire [7:0] comm_diag_val = 8'(frame_err_reg) << scp_pkg::FRAME_ERR_BIT;
	logic [9:0] look;
	// a process, so that contents read inside the function also wake the lookup
	always_comb look = reg_lookup(f_addr, comm_diag_val);
	wire exists = look[9];
	wire can_write = look[8];
	wire [7:0] cur_data = look[7:0];
	// ignition keeps only its low bits, so its answer shows what was stored
	wire [7:0] wr_data = (f_addr == scp_pkg::ADDR_IGN) ? 8'(f_data[scp_pkg::IGN_W-1:0]) : f_data;

	// frames are judged only when chip select rises
	wire frame_end = listen & cs_rise;
	wire len_ok = cnt_reg == scp_pkg::CNT_W'(scp_pkg::FRAME_BITS);
	// no monitoring beyond the length check exists in this mode
	wire bad_len = frame_end & ~len_ok;
	wire do_write = frame_end & len_ok & f_rw & can_write;
	wire do_read = frame_end & len_ok & ~f_rw & exists;
	wire rd_comm = do_read & (f_addr == scp_pkg::ADDR_COMM_DIAG);

	// answer held until the next frame
	always_comb begin
		if (bad_len) begin
			ans_next = {main_diag_in, scp_pkg::ADDR_MAIN_DIAG, 1'b0};
		end else if (do_write) begin
			ans_next = {wr_data, f_addr, 1'b1};
		end else if (do_read) begin
			ans_next = {cur_data, f_addr, 1'b0};
		end else begin
			ans_next = {8'h00, f_addr, f_rw};
		end
	end

	// error flag clears on a read of the communication diagnosis; a new error wins
	always_comb begin
		frame_err_next = frame_err_reg;
		if (rd_comm) begin
			frame_err_next = 1'b0;
		end
		if (bad_len) begin
			frame_err_next = 1'b1;
		end
	end

	// status flag until the first rising clock, then the answer bit by bit
	always_comb begin
		if (wdr_active) begin
			sdo_next = status_flag;
		end else if (cs_fall || (flag_ph_reg && !sclk_rise)) begin
			sdo_next = status_flag;
		end else if (sclk_rise && in_frame) begin
			sdo_next = tx_reg[0];
		end else begin
			sdo_next = sdo_reg;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_d_reg <= 1'b0;
			csn_d_reg <= 1'b1;
			por_d_reg <= 1'b1;
			wdr_d_reg <= 1'b0;
			sdo_reg <= 1'b0;
			oe_reg <= 1'b0;
			flag_ph_reg <= 1'b0;
			frame_err_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_s;
			csn_d_reg <= csn_s;
			por_d_reg <= por_active;
			wdr_d_reg <= wdr_active;
			sdo_reg <= sdo_next;
			// released during power-on reset, and between frames unless a watchdog reset is in progress
			oe_reg <= mode_ok & ~por_active & (wdr_active | ~csn_s);
			flag_ph_reg <= ~csn_s & ((cs_fall & listen) | (flag_ph_reg & ~sclk_rise));
			frame_err_reg <= frame_err_next;
		end
	end

	// receive shifter and bit counter
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_reg <= 16'h0000;
			cnt_reg <= '0;
		end else if (cs_fall) begin
			cnt_reg <= '0;
		end else if (sclk_fall && in_frame) begin
			rx_reg <= {sdi_s, rx_reg[15:1]};
			if (cnt_reg != '1) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

	// transmit shifter takes the pending answer at chip select fall
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_reg <= 16'h0000;
		end else if (cs_fall && listen) begin
			tx_reg <= ans_reg;
		end else if (sclk_rise && in_frame) begin
			tx_reg <= {1'b0, tx_reg[15:1]};
		end
	end

	// pending answer; a reset release overrides any frame result
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ans_reg <= 16'h0000;
		end else if (por_release) begin
			ans_reg <= {op_status_in, scp_pkg::ADDR_OP_STATUS, 1'b0};
		end else if (wdr_release) begin
			ans_reg <= {fwd_status_in, scp_pkg::ADDR_FWD_STATUS, 1'b0};
		end else if (frame_end) begin
			ans_reg <= ans_next;
		end
	end

	// switch-on control registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			out_low_reg <= scp_pkg::CTRL_RESET;
			out_mid_reg <= scp_pkg::CTRL_RESET;
			out_high_reg <= scp_pkg::CTRL_RESET;
			ign_reg <= scp_pkg::CTRL_RESET[scp_pkg::IGN_W-1:0];
		end else if (do_write) begin
			case (f_addr)
				scp_pkg::ADDR_OUT_LOW: out_low_reg <= f_data;
				scp_pkg::ADDR_OUT_MID: out_mid_reg <= f_data;
				scp_pkg::ADDR_OUT_HIGH: out_high_reg <= f_data;
				scp_pkg::ADDR_IGN: ign_reg <= f_data[scp_pkg::IGN_W-1:0];
				default: ign_reg <= ign_reg;
			endcase
		end
	end

	assign link.serial_data_out = sdo_reg;
	assign link.sdo_oe = oe_reg;
	assign output_on = {out_high_reg, out_mid_reg, out_low_reg};
	assign ignition_on = ign_reg;
	assign frame_error_flag = frame_err_reg;
	assign spi_mode = mode_ok;
endmodule

// File: rtl/scp_host.sv
// host end: APB-programmed master that clocks single frames through the link
`timescale 1ns/10ps
module scp_host #(
	parameter logic [7:0] HALF_CYC = 8'(scp_pkg::SCLK_HALF_CYC)
) (
	input wire logic core_clk, // core clock, 25 MHz
	input wire logic nrst, // async reset, active low
	scp_if.host link, // serial pins
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr // APB error, unmapped address
);
	scp_pkg::scp_hstate_type state_reg;
	logic [7:0] tim_reg;
	logic [scp_pkg::CNT_W-1:0] bit_reg;
	logic [scp_pkg::CNT_W-1:0] len_reg;
	logic [15:0] txdata_reg;
	logic [15:0] tx_sh_reg;
	logic [15:0] rx_sh_reg;
	logic [15:0] rxdata_reg;
	logic sclk_reg;
	logic csn_reg;
	logic sdi_reg;
	logic done_reg;
	logic flag_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic sdo_s;

	scp_sync #(
		.W(1),
		.RST_VAL(1'b0)
	) u_sdo_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.d(link.serial_data_line),
		.q(sdo_s)
	);

	// one wait state: pready rises in the second access cycle
	wire access = psel & penable & ~pready_reg;
	wire idle = state_reg == scp_pkg::H_IDLE;
	wire hit_ctrl = paddr == scp_pkg::H_CTRL;
	wire hit_tx = paddr == scp_pkg::H_TXDATA;
	wire hit_stat = paddr == scp_pkg::H_STATUS;
	wire hit_rx = paddr == scp_pkg::H_RXDATA;
	wire mapped = hit_ctrl | hit_tx | hit_stat | hit_rx;
	// a start while busy is dropped; only single frames are ever sent
	wire start = access & pwrite & hit_ctrl & pwdata[scp_pkg::CTRL_START_BIT] & idle;
	wire [scp_pkg::CNT_W-1:0] start_len = pwdata[scp_pkg::CTRL_LEN_LSB +: scp_pkg::CNT_W];
	wire tim_zero = tim_reg == 8'h00;
	wire [scp_pkg::CNT_W-1:0] bit_inc = bit_reg + 1'b1;
	wire [31:0] stat_word = {29'h0000_0000, flag_reg, done_reg, ~idle};
	wire [31:0] rd_mux = hit_ctrl ? {19'h0_0000, len_reg, 8'h00}
		: hit_tx ? {16'h0000, txdata_reg}
		: hit_stat ? stat_word
		: hit_rx ? {16'h0000, rxdata_reg} : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			txdata_reg <= 16'h0000;
		end else begin
			pready_reg <= access;
			pslverr_reg <= access & ~mapped;
			if (access && !pwrite) begin
				prdata_reg <= rd_mux;
			end
			if (access && pwrite && hit_tx) begin
				txdata_reg <= pwdata[15:0];
			end
		end
	end

	// frame sequencer; clock idles low so the first edge is rising
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= scp_pkg::H_IDLE;
			tim_reg <= 8'h00;
			bit_reg <= '0;
			len_reg <= scp_pkg::LEN_RESET;
			tx_sh_reg <= 16'h0000;
			rx_sh_reg <= 16'h0000;
			rxdata_reg <= 16'h0000;
			sclk_reg <= 1'b0;
			csn_reg <= 1'b1;
			sdi_reg <= 1'b0;
			done_reg <= 1'b0;
			flag_reg <= 1'b0;
		end else begin
			case (state_reg)
				scp_pkg::H_IDLE: begin
					if (start) begin
						csn_reg <= 1'b0;
						sdi_reg <= txdata_reg[0];
						tx_sh_reg <= txdata_reg;
						len_reg <= start_len;
						bit_reg <= '0;
						done_reg <= 1'b0;
						tim_reg <= 8'(2 * HALF_CYC - 1);
						state_reg <= scp_pkg::H_LEAD;
					end
				end
				scp_pkg::H_LEAD: begin
					if (!tim_zero) begin
						tim_reg <= tim_reg - 1'b1;
					end else begin
						flag_reg <= sdo_s;
						tim_reg <= HALF_CYC - 1'b1;
						if (len_reg == '0) begin
							csn_reg <= 1'b1;
							state_reg <= scp_pkg::H_GAP;
						end else begin
							sclk_reg <= 1'b1;
							sdi_reg <= tx_sh_reg[0];
							tx_sh_reg <= {1'b0, tx_sh_reg[15:1]};
							state_reg <= scp_pkg::H_HIGH;
						end
					end
				end
				scp_pkg::H_HIGH: begin
					if (!tim_zero) begin
						tim_reg <= tim_reg - 1'b1;
					end else begin
						sclk_reg <= 1'b0;
						tim_reg <= HALF_CYC - 1'b1;
						state_reg <= scp_pkg::H_LOW;
					end
				end
				scp_pkg::H_LOW: begin
					if (!tim_zero) begin
						tim_reg <= tim_reg - 1'b1;
					end else begin
						// captured late in the bit cell, well after the device moved
						rx_sh_reg <= {sdo_s, rx_sh_reg[15:1]};
						bit_reg <= bit_inc;
						tim_reg <= HALF_CYC - 1'b1;
						if (bit_inc == len_reg) begin
							csn_reg <= 1'b1;
							state_reg <= scp_pkg::H_GAP;
						end else begin
							sclk_reg <= 1'b1;
							sdi_reg <= tx_sh_reg[0];
							tx_sh_reg <= {1'b0, tx_sh_reg[15:1]};
							state_reg <= scp_pkg::H_HIGH;
						end
					end
				end
				scp_pkg::H_GAP: begin
					if (!tim_zero) begin
						tim_reg <= tim_reg - 1'b1;
					end else begin
						rxdata_reg <= rx_sh_reg;
						done_reg <= 1'b1;
						state_reg <= scp_pkg::H_IDLE;
					end
				end
				default: state_reg <= scp_pkg::H_IDLE;
			endcase
		end
	end

	assign link.serial_clock_in = sclk_reg;
	assign link.chip_select_low = csn_reg;
	assign link.serial_data_in = sdi_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
endmodule

// File: tb/scp_checker.sv
// concurrent checks on the serial link between host and device
`timescale 1ns/10ps
module scp_checker (
	input wire logic core_clk, // core clock
	input wire logic nrst, // async reset, active low
	input wire logic serial_clock_in, // link clock
	input wire logic chip_select_low, // frame enclose, active low
	input wire logic serial_data_in, // host to device data
	input wire logic serial_data_out, // device to host data
	input wire logic sdo_oe, // device drives data out
	input wire logic cfg_clock_neg_pin, // strap, high for serial mode
	input wire logic cfg_data_neg_pin // strap, low for serial mode
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	wire logic straps_bad = !cfg_clock_neg_pin || cfg_data_neg_pin;
	sequence s_lead;
		!serial_clock_in [*8];
	endsequence
	sequence s_high;
		serial_clock_in [*4] ##1 !serial_clock_in;
	endsequence
	sequence s_low;
		!serial_clock_in [*4];
	endsequence
	a_idle_clock_low: assert property (chip_select_low |-> !serial_clock_in)
		else $error("link clock high outside a frame");
	a_cs_lead_time: assert property ($fell(chip_select_low) |-> s_lead)
		else $error("clock started too soon after select");
	a_clock_high_half: assert property ($rose(serial_clock_in) |-> s_high)
		else $error("clock high phase not four cycles");
	a_clock_low_half: assert property ($fell(serial_clock_in) |-> s_low)
		else $error("clock low phase too short");
	a_sdi_steady_low: assert property ($fell(serial_clock_in) |-> $stable(serial_data_in) [*4])
		else $error("host data moved around the falling clock");
	// device updates only after rising clock, so the late low phase must be quiet
	a_sdo_steady_low: assert property ($fell(serial_clock_in) |-> ##2 $stable(serial_data_out) [*2])
		else $error("device data moved in the low phase");
	a_cs_gap_hold: assert property ($rose(chip_select_low) |-> chip_select_low [*4])
		else $error("select gap too short");
	a_end_on_low: assert property ($rose(chip_select_low) |-> !serial_clock_in && !$past(serial_clock_in))
		else $error("frame ended with clock high");
	a_straps_quiet: assert property (straps_bad [*5] |-> !sdo_oe)
		else $error("data out driven with wrong straps");
	c_frame: cover property ($rose(chip_select_low));
endmodule

// File: tb/serial_ctrl_port_outputs_bench.sv
// self-checking bench: APB host end driving the device end over the link
`timescale 1ns/10ps
module serial_ctrl_port_outputs_bench;
	localparam logic [6:0] LO = scp_pkg::ADDR_OUT_LOW;
	localparam logic [6:0] MI = scp_pkg::ADDR_OUT_MID;
	localparam logic [6:0] HI = scp_pkg::ADDR_OUT_HIGH;
	localparam logic [6:0] IG = scp_pkg::ADDR_IGN;
	localparam logic [6:0] CD = scp_pkg::ADDR_COMM_DIAG;
	localparam logic [6:0] MD = scp_pkg::ADDR_MAIN_DIAG;
	localparam logic [6:0] OS = scp_pkg::ADDR_OP_STATUS;
	localparam logic [6:0] WS = scp_pkg::ADDR_FWD_STATUS;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, frame_error_flag, spi_mode;
	logic por_active = 1'b0, wdr_active = 1'b0;
	logic [7:0] main_diag_in = 8'h02, op_status_in = 8'h3e, fwd_status_in = 8'h5a;
	logic [23:0] output_on;
	logic [3:0] ignition_on;
	logic [15:0] rx;
	logic fl, e;
	logic [31:0] r;
	logic [36:0] tab [12];
	int error_cnt = 0, num_checks = 0;

	always #20 core_clk = ~core_clk;
	scp_if u_scp_if();
	scp_device u_scp_device (.core_clk(core_clk), .nrst(nrst), .link(u_scp_if.dev),
		.por_active(por_active), .wdr_active(wdr_active), .main_diag_in(main_diag_in),
		.op_status_in(op_status_in), .fwd_status_in(fwd_status_in), .output_on(output_on),
		.ignition_on(ignition_on), .frame_error_flag(frame_error_flag), .spi_mode(spi_mode));
	scp_host u_scp_host (.core_clk(core_clk), .nrst(nrst), .link(u_scp_if.host), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	scp_checker u_scp_checker (.core_clk(core_clk), .nrst(nrst),
		.serial_clock_in(u_scp_if.serial_clock_in), .chip_select_low(u_scp_if.chip_select_low),
		.serial_data_in(u_scp_if.serial_data_in), .serial_data_out(u_scp_if.serial_data_out),
		.sdo_oe(u_scp_if.sdo_oe), .cfg_clock_neg_pin(u_scp_if.cfg_clock_neg_pin),
		.cfg_data_neg_pin(u_scp_if.cfg_data_neg_pin));

	function automatic logic [15:0] fr(input logic [7:0] d, input logic [6:0] a, input logic w);
		return {d, a, w};
	endfunction

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic er);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one frame through the host: load, start, poll done, fetch answer
	task automatic xfer(input logic [15:0] f, input logic [4:0] n, output logic [15:0] a,
		output logic flag);
		logic [31:0] q;
		logic er;
		int k;
		apb(1'b1, scp_pkg::H_TXDATA, {16'h0000, f}, q, er);
		apb(1'b1, scp_pkg::H_CTRL, {19'h0_0000, n, 7'h00, 1'b1}, q, er);
		k = 0;
		do begin
			apb(1'b0, scp_pkg::H_STATUS, 32'h0000_0000, q, er);
			k++;
		end while (q[scp_pkg::STAT_DONE_BIT] !== 1'b1 && k < 400);
		chk(32'(q[scp_pkg::STAT_DONE_BIT]), 32'h0000_0001);
		flag = q[scp_pkg::STAT_FLAG_BIT];
		apb(1'b0, scp_pkg::H_RXDATA, 32'h0000_0000, q, er);
		a = q[15:0];
	endtask

	task automatic do_reset();
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
	endtask

	task automatic tend(input string s);
		$display("end of test: %s", s);
	endtask

	initial begin
		#1_000_000;
		error_cnt++;
		finish_test();
	end

	initial begin
		u_scp_if.cfg_clock_neg_pin <= 1'b1;
		u_scp_if.cfg_data_neg_pin <= 1'b0;
		do_reset();
		tab = '{
			{5'd16, fr(8'ha5, LO, 1'b1), fr(op_status_in, OS, 1'b0)},
			{5'd16, fr(8'h3c, MI, 1'b1), fr(8'ha5, LO, 1'b1)},
			{5'd16, fr(8'h81, HI, 1'b1), fr(8'h3c, MI, 1'b1)},
			{5'd16, fr(8'hfa, IG, 1'b1), fr(8'h81, HI, 1'b1)},
			{5'd16, fr(8'h00, LO, 1'b0), fr(8'h0a, IG, 1'b1)},
			{5'd16, fr(8'hff, OS, 1'b1), fr(8'ha5, LO, 1'b0)},
			{5'd16, fr(8'h00, 7'h10, 1'b0), fr(8'h00, OS, 1'b1)},
			// short frame: answer's low byte lands on top of the old upper byte
			{5'd8, fr(8'h00, LO, 1'b0), {7'h10, 1'b0, 8'h00}},
			{5'd16, fr(8'h00, CD, 1'b0), fr(8'h02, MD, 1'b0)},
			// a 17th clock shifts one more, empty, bit in on top
			{5'd17, fr(8'h00, LO, 1'b0), fr(8'h01, CD, 1'b0) >> 1},
			{5'd16, fr(8'h00, LO, 1'b0), fr(8'h02, MD, 1'b0)},
			{5'd16, fr(8'h00, LO, 1'b0), fr(8'ha5, LO, 1'b0)}};
		foreach (tab[i]) begin
			xfer(tab[i][31:16], tab[i][36:32], rx, fl);
			chk(32'(rx), 32'(tab[i][15:0]));
			chk(32'(fl), 32'h0000_0001);
		end
		chk(32'(output_on), 32'h0081_3ca5);
		chk(32'(ignition_on), 32'h0000_000a);
		chk(32'(frame_error_flag), 32'h0000_0001);
		tend("register access");
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk) main_diag_in <= 8'(i);
			xfer(fr(8'h00, LO, 1'b0), 5'd16, rx, fl);
			chk(32'(fl), 32'(i % 4 != 0));
			chk(32'(rx), 32'(fr(8'ha5, LO, 1'b0)));
		end
		tend("status flag");
		@(posedge core_clk);
		main_diag_in <= 8'h02;
		wdr_active <= 1'b1;
		xfer(fr(8'h00, LO, 1'b1), 5'd16, rx, fl);
		chk(32'(rx), 32'h0000_ffff);
		chk(32'(output_on[7:0]), 32'h0000_00a5);
		@(posedge core_clk) wdr_active <= 1'b0;
		xfer(fr(8'h00, LO, 1'b0), 5'd16, rx, fl);
		chk(32'(rx), 32'(fr(fwd_status_in, WS, 1'b0)));
		xfer(fr(8'h00, LO, 1'b0), 5'd16, rx, fl);
		chk(32'(rx), 32'(fr(8'ha5, LO, 1'b0)));
		tend("watchdog reset");
		@(posedge core_clk);
		main_diag_in <= 8'h00;
		por_active <= 1'b1;
		xfer(fr(8'h00, LO, 1'b1), 5'd16, rx, fl);
		chk(32'(rx), 32'h0000_ffff);
		chk(32'(fl), 32'h0000_0001);
		@(posedge core_clk) por_active <= 1'b0;
		xfer(fr(8'h00, LO, 1'b0), 5'd16, rx, fl);
		chk(32'(rx), 32'(fr(op_status_in, OS, 1'b0)));
		tend("power-on reset");
		@(posedge core_clk) u_scp_if.cfg_clock_neg_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(32'(spi_mode), 32'h0000_0000);
		xfer(fr(8'h00, LO, 1'b1), 5'd16, rx, fl);
		chk(32'(rx), 32'h0000_ffff);
		chk(32'(output_on[7:0]), 32'h0000_00a5);
		@(posedge core_clk) u_scp_if.cfg_clock_neg_pin <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(32'(spi_mode), 32'h0000_0001);
		tend("straps");
		do_reset();
		chk(32'(output_on), 32'h0000_0000);
		chk(32'(ignition_on), 32'h0000_0000);
		chk(32'(frame_error_flag), 32'h0000_0000);
		xfer(fr(8'h00, LO, 1'b0), 5'd16, rx, fl);
		chk(32'(rx), 32'(fr(op_status_in, OS, 1'b0)));
		xfer(fr(8'h00, IG, 1'b0), 5'd16, rx, fl);
		chk(32'(rx), 32'(fr(8'h00, LO, 1'b0)));
		apb(1'b0, 12'h010, 32'h0000_0000, r, e);
		chk(32'(e), 32'h0000_0001);
		tend("second reset");
		finish_test();
	end
endmodule
